/* File: spf_position_filter.sv */
// Sampled PID position filter driving a 16-bit DAC code for one servo axis.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Each sample the error is the commanded position minus the encoder count.
// - One term of the output is directly proportional to the present error.
// - The output is K*(e[n]-A*e[n-1]) plus an integrator C*sum(e), once per sample.
// - K is 4*(P+D) gains, K*A is 4 times the derivative gain, C is half the integral gain.
// - With nonzero integral gain the error keeps accumulating until it is zero.
// - The result is a signed 16-bit DAC code spanning the full plus or minus range.
// - Every edge of both encoder channels is one count, four per line.
// - The DAC code changes only once per sample and holds in between.
module spf_position_filter
	import spf_pkg::*;
(
	// Clock and reset.
	input  wire logic                              core_clk,
	input  wire logic                              rst_n,
	// Register port.
	input  wire logic [spf_pkg::SPF_ADDR_W-1:0]    reg_addr,
	input  wire logic [spf_pkg::SPF_DATA_W-1:0]    reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [spf_pkg::SPF_DATA_W-1:0]    reg_rdata_q,
	// Encoder channels.
	input  wire logic                              enc_a,
	input  wire logic                              enc_b,
	// DAC command and its update pulse.
	output logic signed [spf_pkg::SPF_DAC_W-1:0]   dac_code_q,
	output logic                                   dac_load_q
);
	import spf_pkg::*;

	logic                         enable_q;
	logic [SPF_DATA_W-1:0]        divider_q;
	logic [SPF_DATA_W-1:0]        div_cnt_q;
	logic                         tick_q;
	logic [SPF_GAIN_W-1:0]        proportional_gain_q;
	logic [SPF_GAIN_W-1:0]        derivative_gain_q;
	logic [SPF_GAIN_W-1:0]        integral_gain_q;
	logic signed [SPF_POS_W-1:0]  command_q;
	logic signed [SPF_POS_W-1:0]  position;
	logic signed [SPF_POS_W-1:0]  error_q;
	logic signed [SPF_POS_W-1:0]  error_prev_q;
	logic signed [SPF_ACC_W-1:0]  integ_q;
	logic signed [SPF_ACC_W-1:0]  sum_q;
	spf_state_type                state_q;
	logic                         clr_integ;

	spf_quad_decoder u_decoder (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.chan_a     (enc_a),
		.chan_b     (enc_b),
		.position_q (position)
	);

	function automatic logic signed [SPF_ACC_W-1:0] gain_mul(
		input logic [SPF_GAIN_W-1:0] g,
		input logic signed [SPF_POS_W-1:0] e
	);
		logic signed [SPF_ACC_W-1:0] g_wide;
		logic signed [SPF_ACC_W-1:0] e_wide;
		// Both operands are widened first so the product is formed at full width.
		g_wide   = $signed({{(SPF_ACC_W - SPF_GAIN_W){1'b0}}, g});
		e_wide   = SPF_ACC_W'(e);
		gain_mul = g_wide * e_wide;
	endfunction

	function automatic logic signed [SPF_DAC_W-1:0] saturate(
		input logic signed [SPF_ACC_W-1:0] v
	);
		if (v > SPF_ACC_W'(SPF_DAC_MAX)) begin
			saturate = SPF_DAC_MAX;
		end else if (v < SPF_ACC_W'(SPF_DAC_MIN)) begin
			saturate = SPF_DAC_MIN;
		end else begin
			saturate = v[SPF_DAC_W-1:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register writes.

	assign clr_integ = reg_wr && reg_addr == SPF_REG_CTRL && reg_wdata[SPF_CTRL_CLRINT_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q            <= 1'b0;
			divider_q           <= SPF_DATA_W'(SPF_DIV_RESET);
			proportional_gain_q <= '0;
			derivative_gain_q   <= '0;
			integral_gain_q     <= '0;
			command_q           <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				SPF_REG_CTRL:       enable_q <= reg_wdata[SPF_CTRL_ENABLE_BIT];
				// Too short a period would outrun the four-cycle arithmetic pipeline.
				SPF_REG_DIVIDER:    divider_q <= (reg_wdata < SPF_DIV_MIN) ? SPF_DIV_MIN
					: reg_wdata;
				SPF_REG_PROP_GAIN:  proportional_gain_q <= reg_wdata[SPF_GAIN_W-1:0];
				SPF_REG_DERIV_GAIN: derivative_gain_q <= reg_wdata[SPF_GAIN_W-1:0];
				SPF_REG_INTEG_GAIN: integral_gain_q <= reg_wdata[SPF_GAIN_W-1:0];
				SPF_REG_COMMAND:    command_q <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample tick divider.

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (div_cnt_q + 32'h1 >= divider_q) begin
			div_cnt_q <= '0;
			tick_q    <= enable_q;
		end else begin
			div_cnt_q <= div_cnt_q + 32'h1;
			tick_q    <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Filter pipeline: error, filter sum, output.

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SPF_IDLE;
		end else begin
			case (state_q)
				SPF_IDLE: state_q <= tick_q ? SPF_ERR : SPF_IDLE;
				SPF_ERR:  state_q <= SPF_FILT;
				SPF_FILT: state_q <= SPF_OUT;
				SPF_OUT:  state_q <= SPF_IDLE;
				default:  state_q <= SPF_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			error_q      <= '0;
			error_prev_q <= '0;
		end else if (state_q == SPF_IDLE && tick_q) begin
			error_q      <= command_q - position;
			error_prev_q <= error_q;
		end
	end

	// Integrator: C*z/(z-1) adds the present error before it is used.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			integ_q <= '0;
		end else if (state_q == SPF_ERR) begin
			integ_q <= integ_q + gain_mul(integral_gain_q, error_q);
		end else if (clr_integ) begin
			integ_q <= '0;
		end
	end

	// K*(e - A*e1) = 4*(P+D)*e - 4*D*e1; integral term scaled by C = I/2.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_q <= '0;
		end else if (state_q == SPF_FILT) begin
			sum_q <= ((gain_mul(proportional_gain_q, error_q)
				+ gain_mul(derivative_gain_q, error_q)
				- gain_mul(derivative_gain_q, error_prev_q)) <<< SPF_K_SHIFT)
				+ (integ_q >>> SPF_C_SHIFT);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_code_q <= '0;
			dac_load_q <= 1'b0;
		end else if (state_q == SPF_OUT) begin
			dac_code_q <= saturate(sum_q);
			dac_load_q <= 1'b1;
		end else begin
			dac_load_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads, answered in the cycle after the strobe.

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				SPF_REG_CTRL:       reg_rdata_q <= {31'h0, enable_q};
				SPF_REG_DIVIDER:    reg_rdata_q <= divider_q;
				SPF_REG_PROP_GAIN:  reg_rdata_q <= {16'h0, proportional_gain_q};
				SPF_REG_DERIV_GAIN: reg_rdata_q <= {16'h0, derivative_gain_q};
				SPF_REG_INTEG_GAIN: reg_rdata_q <= {16'h0, integral_gain_q};
				SPF_REG_COMMAND:    reg_rdata_q <= command_q;
				SPF_REG_POSITION:   reg_rdata_q <= position;
				SPF_REG_ERROR:      reg_rdata_q <= error_q;
				SPF_REG_DAC:        reg_rdata_q <= {{(SPF_DATA_W - SPF_DAC_W){dac_code_q[SPF_DAC_W-1]}},
					dac_code_q};
				SPF_REG_STATUS:     reg_rdata_q <= {30'h0, state_q};
				default:            reg_rdata_q <= '0;
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_error_sample : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_IDLE && tick_q) |=> error_q == $past(command_q) - $past(position))
		else $error("Error is not command minus position.");

	a_prop_term : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_FILT && derivative_gain_q == 0 && integral_gain_q == 0
			&& integ_q == 0) |=> sum_q == (gain_mul($past(proportional_gain_q),
			$past(error_q)) <<< 2))
		else $error("Proportional term is not four times gain times error.");

	a_filter_eq : assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == SPF_FILT |=> sum_q == (((gain_mul($past(proportional_gain_q), $past(error_q))
			+ gain_mul($past(derivative_gain_q), $past(error_q))
			- gain_mul($past(derivative_gain_q), $past(error_prev_q))) <<< 2)
			+ ($past(integ_q) >>> 1)))
		else $error("Filter sum does not match the transfer function.");

	a_coef_deriv : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_FILT && proportional_gain_q == 0 && integ_q == 0
			&& error_q == error_prev_q) |=> sum_q == 0)
		else $error("Derivative term is nonzero for a steady error.");

	a_integ_grows : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_ERR && integral_gain_q != 0 && error_q > 0)
			|=> integ_q > $past(integ_q))
		else $error("Integrator stopped while error remained.");

	a_dac_range : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_OUT && sum_q <= 48'sh7fff && sum_q >= -48'sh8000)
			|=> dac_code_q == $past(sum_q[15:0]))
		else $error("In-range result not passed to the DAC.");

	a_dac_hold : assert property (@(posedge core_clk) disable iff (!rst_n)
		!dac_load_q |-> dac_code_q == $past(dac_code_q))
		else $error("DAC code changed outside an update.");

	a_dac_sat : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_OUT && sum_q > 48'sh7fff) |=> dac_code_q == 16'sh7fff)
		else $error("Positive overflow did not saturate.");

	a_dac_sat_neg : assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == SPF_OUT && sum_q < -48'sh8000) |=> dac_code_q == -16'sh8000)
		else $error("Negative overflow did not saturate.");

	a_tick_spacing : assert property (@(posedge core_clk) disable iff (!rst_n)
		tick_q |=> !tick_q [*7])
		else $error("Sample ticks closer than the least divider.");

	c_update : cover property (@(posedge core_clk) disable iff (!rst_n) dac_load_q);
	c_sat_pos : cover property (@(posedge core_clk) disable iff (!rst_n) dac_code_q == 16'sh7fff);
	c_sat_neg : cover property (@(posedge core_clk) disable iff (!rst_n) dac_code_q == -16'sh8000);
	c_integ : cover property (@(posedge core_clk) disable iff (!rst_n) integ_q != 0);

endmodule

/* File: spf_pkg.sv */
// Package with constants, register map and types for the servo position filter.
package spf_pkg;

	// Register indices on the plain register port.
	localparam logic [3:0] SPF_REG_CTRL      = 4'h0;
	localparam logic [3:0] SPF_REG_DIVIDER   = 4'h1;
	localparam logic [3:0] SPF_REG_PROP_GAIN = 4'h2;
	localparam logic [3:0] SPF_REG_DERIV_GAIN = 4'h3;
	localparam logic [3:0] SPF_REG_INTEG_GAIN = 4'h4;
	localparam logic [3:0] SPF_REG_COMMAND   = 4'h5;
	localparam logic [3:0] SPF_REG_POSITION  = 4'h6;
	localparam logic [3:0] SPF_REG_ERROR     = 4'h7;
	localparam logic [3:0] SPF_REG_DAC       = 4'h8;
	localparam logic [3:0] SPF_REG_STATUS    = 4'h9;

	localparam int SPF_ADDR_W = 4;
	localparam int SPF_DATA_W = 32;
	localparam int SPF_POS_W  = 32;
	localparam int SPF_GAIN_W = 16;
	localparam int SPF_DAC_W  = 16;
	localparam int SPF_ACC_W  = 48;

	// Control register fields.
	localparam int SPF_CTRL_ENABLE_BIT = 0;
	localparam int SPF_CTRL_CLRINT_BIT = 1;

	// Coefficient scaling: K = 4*(proportional + derivative), C = integral / 2.
	localparam int SPF_K_SHIFT = 2;
	localparam int SPF_C_SHIFT = 1;

	// Sample period 1 ms at 200 MHz as divider reset value.
	localparam real SPF_SAMPLE_PERIOD_NS = 1000000.0;
	localparam real SPF_CLK_PERIOD_NS    = 5.0;
	localparam int  SPF_DIV_RESET        = int'(SPF_SAMPLE_PERIOD_NS / SPF_CLK_PERIOD_NS);
	localparam logic [SPF_DATA_W-1:0] SPF_DIV_MIN = 32'h0000_0008;

	localparam logic signed [SPF_DAC_W-1:0] SPF_DAC_MAX = 16'sh7fff;
	localparam logic signed [SPF_DAC_W-1:0] SPF_DAC_MIN = -16'sh8000;

	// Arithmetic pipeline states, Gray coded along the path.
	typedef enum logic [1:0] {
		SPF_IDLE  = 2'b00,
		SPF_ERR   = 2'b01,
		SPF_FILT  = 2'b11,
		SPF_OUT   = 2'b10
	} spf_state_type;

endpackage

/* File: spf_quad_decoder.sv */
// Quadrature decoder that counts every edge of both encoder channels.
`timescale 1ns/1ps
module spf_quad_decoder
	import spf_pkg::*;
(
	// Clock and reset.
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// Encoder channels, synchronous to core_clk.
	input  wire logic                        chan_a,
	input  wire logic                        chan_b,
	// Position count.
	output logic signed [spf_pkg::SPF_POS_W-1:0] position_q
);
	import spf_pkg::*;

	logic [1:0] prev_q;
	logic [1:0] curr;
	logic       step_up;
	logic       step_dn;

	assign curr = {chan_a, chan_b};

	// Gray sequence 00-01-11-10 counts up; each transition is one count.
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case ({prev_q, curr})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1;
			default: begin
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 2'h0;
		end else begin
			prev_q <= curr;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			position_q <= '0;
		end else if (step_up) begin
			position_q <= position_q + 32'sh1;
		end else if (step_dn) begin
			position_q <= position_q - 32'sh1;
		end
	end

	a_quad_step_one : assert property (@(posedge core_clk) disable iff (!rst_n)
		(step_up || step_dn) |=> ($past(step_up) ? position_q == $past(position_q) + 1
			: position_q == $past(position_q) - 1))
		else $error("Quadrature edge did not move the count by one.");

	a_quad_still : assert property (@(posedge core_clk) disable iff (!rst_n)
		!(step_up || step_dn) |=> $stable(position_q))
		else $error("Count moved without a channel edge.");

endmodule

/* File: spf_axis_model.sv */
// Encoder and DAC model standing at the far side of the servo position filter.
`timescale 1ns/1ps
module spf_axis_model (
	// Clock.
	input  wire logic               core_clk,
	// DAC command from the filter.
	input  wire logic signed [15:0] dac_code_q,
	input  wire logic               dac_load_q,
	// Encoder channels to the filter.
	output logic                    enc_a,
	output logic                    enc_b
);
	logic        [1:0]  phase_q = 2'b00;
	logic signed [15:0] amp_code_q = 16'sh0000;

	// Channels follow the quadrature cycle 00, 01, 11, 10 when moving up.
	assign enc_a = phase_q[1];
	assign enc_b = phase_q[0];

	// The amplifier only sees a new code on a load, as a zero-order hold would.
	always @(posedge core_clk) begin
		if (dac_load_q) amp_code_q <= dac_code_q;
	end

	// One quadrature edge per call step; slow spacing keeps every edge countable.
	task automatic step(input bit up, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			phase_q <= up ? {phase_q[0], ~phase_q[1]} : {~phase_q[0], phase_q[1]};
			repeat (3) @(posedge core_clk);
		end
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the servo position filter.
`timescale 1ns/1ps
module tb_top;
	import spf_pkg::*;
	logic               core_clk = 1'b0;
	logic               rst_n = 1'b0;
	logic        [3:0]  reg_addr = 4'h0;
	logic        [31:0] reg_wdata = 32'h0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic        [31:0] reg_rdata_q;
	logic               enc_a;
	logic               enc_b;
	logic               dac_load_q;
	logic signed [15:0] dac_code_q;
	logic        [15:0] last_code = 16'h0;
	logic        [31:0] exp_rd[$];
	logic        [15:0] exp_dac[$];
	int                 failures = 0;
	int                 total_checks = 0;
	int                 loads = 0;
	int                 gap = 0;
	bit                 rd_seen = 1'b0;
	int                 e;

	always #2.5 core_clk = ~core_clk;

	spf_position_filter dut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .enc_a(enc_a),
		.enc_b(enc_b), .dac_code_q(dac_code_q), .dac_load_q(dac_load_q));

	spf_axis_model u_axis (
		.core_clk(core_clk), .dac_code_q(dac_code_q), .dac_load_q(dac_load_q),
		.enc_a(enc_a), .enc_b(enc_b));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Idle bus lines carry noise so that a decode that ignores the strobe shows up.
		reg_addr <= 4'($urandom());
		reg_wdata <= $urandom();
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d);
		exp_rd.push_back(d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= 4'($urandom());
		reg_wdata <= $urandom();
	endtask

	// Disabling right after the last load is safe: the next tick is far away.
	task automatic run(input int n);
		int w = 0;
		loads = 0;
		wr(SPF_REG_CTRL, 32'h1);
		while (loads < n && w < 2000) begin
			@(posedge core_clk);
			w++;
		end
		wr(SPF_REG_CTRL, 32'h0);
		if (w >= 2000) check("load count", n, loads);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Results are compared on the falling edge, once the rising edge has settled.
	always @(posedge core_clk) rd_seen <= reg_rd;

	always @(negedge core_clk) begin
		if (rd_seen) check("read data", exp_rd.size() ? exp_rd.pop_front() : 32'hx, reg_rdata_q);
		if (dac_load_q === 1'b1) begin
			check("dac code", {16'h0, exp_dac.size() ? exp_dac.pop_front() : 16'hx},
				{16'h0, dac_code_q});
			if (loads > 0) check("sample spacing", 32'd16, gap);
			loads++;
			gap = 1;
		end else begin
			check("held code", {16'h0, last_code}, {16'h0, dac_code_q});
			check("amp hold", {16'h0, last_code}, {16'h0, u_axis.amp_code_q});
			gap++;
		end
		last_code = dac_code_q;
	end

	initial begin
		#200us;
		failures++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h0508f71d));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(SPF_REG_DIVIDER, 32'd200000);
		rd(SPF_REG_PROP_GAIN, 32'h0);
		wr(4'hf, 32'hffff_ffff);
		rd(4'hf, 32'h0);
		wr(SPF_REG_DIVIDER, 32'h3);
		rd(SPF_REG_DIVIDER, 32'h8);
		wr(SPF_REG_DIVIDER, 32'd16);
		wr(SPF_REG_PROP_GAIN, 32'hffff_0005);
		rd(SPF_REG_PROP_GAIN, 32'h5);
		$display("test registers done");
		u_axis.step(1'b1, 10);
		u_axis.step(1'b0, 3);
		rd(SPF_REG_POSITION, 32'd7);
		$display("test encoder done");
		e = int'($urandom_range(200)) - 100;
		wr(SPF_REG_PROP_GAIN, 32'h1);
		wr(SPF_REG_COMMAND, 32'(7 + e));
		repeat (3) exp_dac.push_back(16'(4 * e));
		run(3);
		rd(SPF_REG_ERROR, 32'(e));
		$display("test proportional done");
		wr(SPF_REG_PROP_GAIN, 32'h0);
		wr(SPF_REG_DERIV_GAIN, 32'h2);
		wr(SPF_REG_COMMAND, 32'd27);
		exp_dac.push_back(16'(160 - 8 * e));
		exp_dac.push_back(16'h0);
		run(2);
		rd(SPF_REG_DERIV_GAIN, 32'h2);
		rd(SPF_REG_COMMAND, 32'd27);
		$display("test derivative done");
		wr(SPF_REG_DERIV_GAIN, 32'h0);
		wr(SPF_REG_INTEG_GAIN, 32'h2);
		exp_dac.push_back(16'd20);
		exp_dac.push_back(16'd40);
		exp_dac.push_back(16'd60);
		run(3);
		wr(SPF_REG_CTRL, 32'h2);
		exp_dac.push_back(16'd20);
		run(1);
		rd(SPF_REG_INTEG_GAIN, 32'h2);
		rd(SPF_REG_CTRL, 32'h0);
		rd(SPF_REG_STATUS, 32'h0);
		$display("test integral done");
		wr(SPF_REG_INTEG_GAIN, 32'h0);
		wr(SPF_REG_PROP_GAIN, 32'd1000);
		repeat (2) exp_dac.push_back(16'h7fff);
		run(2);
		wr(SPF_REG_COMMAND, 32'(-13));
		repeat (2) exp_dac.push_back(16'h8000);
		run(2);
		rd(SPF_REG_DAC, 32'hffff_8000);
		rd(SPF_REG_ERROR, 32'hffff_ffec);
		repeat (4) @(posedge core_clk);
		$display("test saturation done");
		final_report();
	end
endmodule
